// [atd_top.sv]
// Functional notes
// - polarity bit swaps the differential input pair
// - control b bits 4 and 3 read zero
// - trigger select ignored unless auto trigger on
// - rising edge of selected flag starts conversion
// - switching clear source to set source triggers
// - switching to free running never triggers
// - select codes map to the seven sources
// - disable bit turns off pin input buffer
// - disabled pin reads back as zero
// - auto trigger enable bit starts on edges
// - done flag set on completion, free-run trigger
// - bipolar bit selects signed nine-bit mode
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module atd_top
    import atd_pkg::*;
(
    input  wire logic                     sys_clk_in,
    input  wire logic                     rst_in,
    input  wire logic [7:0]               addr_in,
    input  wire logic [7:0]               wdata_in,
    input  wire logic                     wr_in,
    input  wire logic                     rd_in,
    output logic      [7:0]               rdata_out,
    input  wire logic [ATD_NUM_FLAGS-1:0] peer_flags_in,
    input  wire logic                     conversion_done_in,
    input  wire logic                     conversion_busy_in,
    input  wire logic [1:0]               diff_pos_ch_in,
    input  wire logic [1:0]               diff_neg_ch_in,
    output logic [1:0]                    gain_pos_ch_out,
    output logic [1:0]                    gain_neg_ch_out,
    output logic                          conversion_start_out,
    output logic                          converter_enable_out,
    output logic                          bipolar_mode_out,
    output logic                          comparator_mux_out,
    output logic [3:0]                    adc_misc_out,
    input  wire logic [ATD_DIDR_W-1:0]    pin_raw_in,
    output logic [ATD_DIDR_W-1:0]         pin_read_out,
    output logic [ATD_DIDR_W-1:0]         input_buffer_disable_out
);
    atd_trig_if tif ();

    logic                    converter_enable_q;
    logic                    auto_trigger_enable_q;
    logic                    conversion_done_flag_q;
    logic [3:0]              misc_q;
    logic                    bipolar_mode_q;
    logic                    comparator_mux_q;
    logic                    input_polarity_reverse_q;
    logic [ATD_SEL_W-1:0]    trigger_source_select_q;
    logic [ATD_DIDR_W-1:0]   didr_q;
    logic [ATD_DIDR_W-1:0]   didr_d;
    logic [7:0]              rdata_q;
    logic                    start_q;
    logic [1:0]              pos_q;
    logic [1:0]              neg_q;
    logic                    wr_a;
    logic                    wr_b;
    logic                    wr_didr;
    logic                    sw_start;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    assign wr_a     = wr_in && hit(addr_in, ATD_ADDR_CTRL_A);
    assign wr_b     = wr_in && hit(addr_in, ATD_ADDR_CTRL_B);
    assign wr_didr  = wr_in && hit(addr_in, ATD_ADDR_DIDR);
    assign sw_start = wr_a && wdata_in[ATD_A_START_BIT];

    // control a
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            converter_enable_q    <= 1'b0;
            auto_trigger_enable_q <= 1'b0;
            misc_q                <= ATD_CTRL_RESET[3:0];
        end else if (wr_a) begin
            converter_enable_q    <= wdata_in[ATD_A_EN_BIT];
            auto_trigger_enable_q <= wdata_in[ATD_A_ATE_BIT];
            misc_q                <= wdata_in[3:0] & ATD_A_STORE_MASK[3:0];
        end
    end

    // done flag: a completion in the same cycle as a write-one clear wins
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            conversion_done_flag_q <= 1'b0;
        end else if (conversion_done_in) begin
            conversion_done_flag_q <= 1'b1;
        end else if (wr_a && wdata_in[ATD_A_DONE_BIT]) begin
            conversion_done_flag_q <= 1'b0;
        end
    end

    // control b
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            bipolar_mode_q           <= 1'b0;
            comparator_mux_q         <= 1'b0;
            input_polarity_reverse_q <= 1'b0;
            trigger_source_select_q  <= ATD_SRC_FREE;
        end else if (wr_b) begin
            bipolar_mode_q           <= wdata_in[ATD_B_BIP_BIT];
            comparator_mux_q         <= wdata_in[ATD_B_CMUX_BIT];
            input_polarity_reverse_q <= wdata_in[ATD_B_IPR_BIT];
            trigger_source_select_q  <= wdata_in[ATD_SEL_W-1:0];
        end
    end

    // input disable
    always_comb begin
        didr_d = didr_q;
        if (wr_didr) begin
            didr_d = wdata_in[ATD_DIDR_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            didr_q <= ATD_DIDR_RESET[ATD_DIDR_W-1:0];
        end else begin
            didr_q <= didr_d;
        end
    end

    // readback is masked with the next disable value so the output never lags the register
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pin_read_out <= '0;
        end else begin
            pin_read_out <= pin_raw_in & ~didr_d;
        end
    end

    // read port: data only in the cycle after the strobe, unmapped reads zero
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rdata_q <= 8'h00;
        end else if (rd_in) begin
            if (hit(addr_in, ATD_ADDR_CTRL_A)) begin
                rdata_q <= {converter_enable_q, conversion_busy_in, auto_trigger_enable_q,
                            conversion_done_flag_q, misc_q};
            end else if (hit(addr_in, ATD_ADDR_CTRL_B)) begin
                rdata_q <= {bipolar_mode_q, comparator_mux_q, input_polarity_reverse_q,
                            2'h0, trigger_source_select_q} & ~ATD_B_RSV_MASK;
            end else if (hit(addr_in, ATD_ADDR_DIDR)) begin
                rdata_q <= {2'h0, didr_q};
            end else begin
                rdata_q <= 8'h00;
            end
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign tif.sel        = trigger_source_select_q;
    assign tif.peer_flags = peer_flags_in;
    assign tif.done_flag  = conversion_done_flag_q;
    assign tif.auto_en    = auto_trigger_enable_q;
    assign tif.conv_en    = converter_enable_q;

    atd_trig_edge u_trig (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .tif        (tif)
    );

    // start request: auto trigger pulse or a software start while enabled
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            start_q <= 1'b0;
        end else begin
            start_q <= tif.trig || (sw_start && (converter_enable_q || wdata_in[ATD_A_EN_BIT]));
        end
    end

    // polarity swap of the differential pair feeding the gain stage
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pos_q <= 2'h0;
            neg_q <= 2'h0;
        end else if (input_polarity_reverse_q) begin
            pos_q <= diff_neg_ch_in;
            neg_q <= diff_pos_ch_in;
        end else begin
            pos_q <= diff_pos_ch_in;
            neg_q <= diff_neg_ch_in;
        end
    end

    assign rdata_out                = rdata_q;
    assign conversion_start_out     = start_q;
    assign converter_enable_out     = converter_enable_q;
    assign bipolar_mode_out         = bipolar_mode_q;
    assign comparator_mux_out       = comparator_mux_q;
    assign adc_misc_out             = misc_q;
    assign input_buffer_disable_out = didr_q;
    assign gain_pos_ch_out          = pos_q;
    assign gain_neg_ch_out          = neg_q;

    sequence s_read_b;
        rd_in && hit(addr_in, ATD_ADDR_CTRL_B);
    endsequence

    chk_reserved_zero : assert property (@(posedge sys_clk_in) disable iff (rst_in)
        s_read_b |=> (rdata_out[4:3] == 2'h0)) else $error("reserved bits not zero");
    chk_done_sets : assert property (@(posedge sys_clk_in) disable iff (rst_in)
        conversion_done_in |=> conversion_done_flag_q) else $error("done flag not set");
    chk_pin_masked : assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (pin_read_out & input_buffer_disable_out) == '0) else $error("disabled pin reads one");
    chk_didr_write : assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr_didr |=> (input_buffer_disable_out == $past(wdata_in[ATD_DIDR_W-1:0])))
        else $error("input disable not taken");
    chk_trig_starts : assert property (@(posedge sys_clk_in) disable iff (rst_in)
        tif.trig |=> conversion_start_out) else $error("trigger lost");
    chk_polarity_swap : assert property (@(posedge sys_clk_in) disable iff (rst_in)
        input_polarity_reverse_q |=> (gain_pos_ch_out == $past(diff_neg_ch_in)))
        else $error("pair not swapped");
    chk_bipolar_bit : assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr_b |=> (bipolar_mode_out == $past(wdata_in[ATD_B_BIP_BIT])))
        else $error("bipolar bit not taken");
endmodule
`default_nettype wire

// [atd_pkg.sv]
package atd_pkg;
    // register byte addresses
    localparam logic [7:0] ATD_ADDR_CTRL_A  = 8'h06;
    localparam logic [7:0] ATD_ADDR_CTRL_B  = 8'h03;
    localparam logic [7:0] ATD_ADDR_DIDR    = 8'h14;

    // adc_control_a fields
    localparam int ATD_A_EN_BIT    = 7;
    localparam int ATD_A_START_BIT = 6;
    localparam int ATD_A_ATE_BIT   = 5;
    localparam int ATD_A_DONE_BIT  = 4;
    localparam logic [7:0] ATD_A_STORE_MASK = 8'h0F;

    // adc_control_b fields
    localparam int ATD_B_BIP_BIT   = 7;
    localparam int ATD_B_CMUX_BIT  = 6;
    localparam int ATD_B_IPR_BIT   = 5;
    localparam logic [7:0] ATD_B_WR_MASK  = 8'hE7;
    localparam logic [7:0] ATD_B_RSV_MASK = 8'h18;

    // digital_input_disable_0: six live bits, two top bits read zero
    localparam int         ATD_DIDR_W       = 6;
    localparam logic [7:0] ATD_DIDR_RESET   = 8'h00;
    localparam logic [7:0] ATD_CTRL_RESET   = 8'h00;

    // trigger source codes
    localparam int         ATD_SEL_W        = 3;
    localparam logic [2:0] ATD_SRC_FREE     = 3'h0;
    localparam logic [2:0] ATD_SRC_COMP     = 3'h1;
    localparam logic [2:0] ATD_SRC_EXT0     = 3'h2;
    localparam logic [2:0] ATD_SRC_CMPA     = 3'h3;
    localparam logic [2:0] ATD_SRC_OVF      = 3'h4;
    localparam logic [2:0] ATD_SRC_CMPB     = 3'h5;
    localparam logic [2:0] ATD_SRC_PCINT    = 3'h6;
    localparam int         ATD_NUM_FLAGS    = 6;
endpackage

// [atd_trig_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface atd_trig_if;
    import atd_pkg::*;
    logic [ATD_SEL_W-1:0]     sel;
    logic [ATD_NUM_FLAGS-1:0] peer_flags;
    logic                     done_flag;
    logic                     auto_en;
    logic                     conv_en;
    logic                     trig;
    modport ctl (output sel, output peer_flags, output done_flag, output auto_en,
                 output conv_en, input trig);
    modport trg (input sel, input peer_flags, input done_flag, input auto_en,
                 input conv_en, output trig);
endinterface
`default_nettype wire

// [atd_trig_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module atd_trig_edge
    import atd_pkg::*;
(
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    atd_trig_if.trg   tif
);
    logic [ATD_NUM_FLAGS-1:0] meta_q;
    logic [ATD_NUM_FLAGS-1:0] sync_q;
    logic                     prev_q;
    logic [ATD_SEL_W-1:0]     sel_q;
    logic                     trig_q;
    logic                     cur;
    logic                     to_free;

    // source decode; code 7 has no flag behind it
    function automatic logic pick(input logic [ATD_SEL_W-1:0] s,
                                  input logic [ATD_NUM_FLAGS-1:0] f,
                                  input logic d);
        case (s)
            ATD_SRC_FREE:  pick = d;
            ATD_SRC_COMP:  pick = f[0];
            ATD_SRC_EXT0:  pick = f[1];
            ATD_SRC_CMPA:  pick = f[2];
            ATD_SRC_OVF:   pick = f[3];
            ATD_SRC_CMPB:  pick = f[4];
            ATD_SRC_PCINT: pick = f[5];
            default:       pick = 1'b0;
        endcase
    endfunction

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= tif.peer_flags;
            sync_q <= meta_q;
        end
    end

    assign cur     = pick(tif.sel, sync_q, tif.done_flag);
    // moving onto free running must not fire off an already set done flag
    assign to_free = (tif.sel == ATD_SRC_FREE) && (sel_q != ATD_SRC_FREE);

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            prev_q <= 1'b0;
            sel_q  <= ATD_SRC_FREE;
            trig_q <= 1'b0;
        end else begin
            prev_q <= cur;
            sel_q  <= tif.sel;
            // a source switch from clear to set is an edge as well
            trig_q <= tif.auto_en && tif.conv_en && cur && !prev_q && !to_free;
        end
    end

    assign tif.trig = trig_q;

    chk_no_auto_trig : assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !tif.auto_en |=> !tif.trig) else $error("trigger while auto trigger off");
    chk_free_switch : assert property (@(posedge sys_clk_in) disable iff (rst_in)
        to_free |=> !tif.trig) else $error("trigger on switch to free running");
    chk_undef_source : assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (tif.sel == 3'h7) |=> !tif.trig) else $error("trigger from undefined source");
    // built from the synced comparator flag alone, so a broken decode or edge store shows up
    sequence s_comp_rise;
        tif.auto_en && tif.conv_en && (tif.sel == ATD_SRC_COMP) && $stable(tif.sel)
            && $rose(sync_q[0]);
    endsequence

    chk_rise_fires : assert property (@(posedge sys_clk_in) disable iff (rst_in)
        s_comp_rise |=> tif.trig) else $error("rising selected flag gave no trigger");
    chk_one_shot : assert property (@(posedge sys_clk_in) disable iff (rst_in)
        tif.trig |=> !tif.trig) else $error("trigger longer than one cycle");
endmodule
`default_nettype wire

// [atd_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module atd_far_model #(
    parameter int CONV_CYC = 10
) (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic [5:0] flag_req_in,
    input  wire logic       conversion_start_in,
    output logic      [5:0] peer_flags_out,
    output logic            conversion_done_out,
    output logic            conversion_busy_out
);
    int cnt_q;
    // peer sources hand over clean levels on the system clock
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            peer_flags_out <= 6'h00;
        end else begin
            peer_flags_out <= flag_req_in;
        end
    end
    // a start while busy is dropped, as the real core would do
    always_ff @(posedge sys_clk_in) begin
        conversion_done_out <= 1'b0;
        if (rst_in) begin
            cnt_q <= 0;
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
            conversion_done_out <= (cnt_q == 1);
        end else if (conversion_start_in) begin
            cnt_q <= CONV_CYC;
        end
    end
    assign conversion_busy_out = (cnt_q > 0);
endmodule
`default_nettype wire

// [atd_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module atd_top_test;
    import atd_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdat = 8'h00;
    logic       wr_s = 1'b0;
    logic       rd_s = 1'b0;
    logic [7:0] rdat;
    logic [5:0] pf;
    logic       done;
    logic       busy;
    logic [1:0] dp = 2'h0;
    logic [1:0] dn = 2'h0;
    logic [1:0] gp;
    logic [1:0] gn;
    logic       cs;
    logic [5:0] raw = 6'h00;
    logic [5:0] prd;
    logic [5:0] ibd;
    logic [5:0] freq = 6'h00;
    logic [7:0] rv;
    logic [7:0] v;
    logic       en_o;
    logic       bip_o;
    logic       cmx_o;
    logic [3:0] misc_o;
    logic [7:0] mdl_b = 8'h00;
    logic [7:0] mdl_d = 8'h00;
    int         n_errors = 0;
    int         total_checks = 0;
    int         n_st = 0;
    int         cyc = 0;
    int         s0;

    atd_top u_dut (.sys_clk_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdat),
        .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdat), .peer_flags_in(pf),
        .conversion_done_in(done), .conversion_busy_in(busy), .diff_pos_ch_in(dp),
        .diff_neg_ch_in(dn), .gain_pos_ch_out(gp), .gain_neg_ch_out(gn),
        .conversion_start_out(cs), .converter_enable_out(en_o), .bipolar_mode_out(bip_o),
        .comparator_mux_out(cmx_o), .adc_misc_out(misc_o), .pin_raw_in(raw), .pin_read_out(prd),
        .input_buffer_disable_out(ibd));
    atd_far_model u_far (.sys_clk_in(clk), .rst_in(rst), .flag_req_in(freq),
        .conversion_start_in(cs), .peer_flags_out(pf), .conversion_done_out(done),
        .conversion_busy_out(busy));

    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (cs === 1'b1) n_st++;
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one idle cycle between accesses keeps each strobe single-driven per step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr_s <= 1'b1;
        // register model: reserved bits never come back
        if (a == ATD_ADDR_CTRL_B) mdl_b = d & 8'hE7;
        if (a == ATD_ADDR_DIDR) mdl_d = d & 8'h3F;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdat;
    endtask
    task automatic trig(input logic [7:0] sel, input logic [5:0] f, input int e);
        wr(ATD_ADDR_CTRL_B, sel);
        s0 = n_st;
        freq <= f;
        repeat (8) @(posedge clk);
        freq <= 6'h00;
        repeat (16) @(posedge clk);
        `CHK(n_st - s0, e)
    endtask

    initial begin
        void'($urandom(13));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(ATD_ADDR_CTRL_B, rv);
        `CHK(rv, 8'h00)
        rd(ATD_ADDR_DIDR, rv);
        `CHK(rv, 8'h00)
        wr(ATD_ADDR_CTRL_B, 8'hFF);
        rd(ATD_ADDR_CTRL_B, rv);
        `CHK(rv, 8'hE7)
        `CHK(bip_o, 1'b1)
        `CHK(cmx_o, 1'b1)
        wr(ATD_ADDR_CTRL_A, 8'h0A);
        rd(ATD_ADDR_CTRL_A, rv);
        `CHK(rv, 8'h0A)
        `CHK(misc_o, 4'hA)
        wr(8'h55, 8'hFF);
        rd(8'h55, rv);
        `CHK(rv, 8'h00)
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            v = 8'($urandom);
            raw <= 6'($urandom);
            wr(ATD_ADDR_DIDR, v);
            rd(ATD_ADDR_DIDR, rv);
            `CHK(rv, mdl_d)
            `CHK(ibd, v[5:0])
            `CHK(prd, raw & ~v[5:0])
        end
        $display("test registers done");
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            dp <= 2'($urandom);
            dn <= 2'($urandom);
            wr(ATD_ADDR_CTRL_B, 8'(i << 5));
            repeat (2) @(posedge clk);
            #1;
            `CHK(gp, i ? dn : dp)
            `CHK(gn, i ? dp : dn)
        end
        $display("test polarity done");
        wr(ATD_ADDR_CTRL_A, 8'hA0);
        #1;
        `CHK(en_o, 1'b1)
        for (int c = 1; c < 7; c++) trig(8'(c), 6'h01 << (c - 1), 1);
        trig(8'h07, 6'h3F, 0);
        wr(ATD_ADDR_CTRL_A, 8'h80);
        trig(8'h01, 6'h01, 0);
        wr(ATD_ADDR_CTRL_A, 8'h20);
        trig(8'h02, 6'h02, 0);
        $display("test trigger sources done");
        wr(ATD_ADDR_CTRL_A, 8'hA0);
        wr(ATD_ADDR_CTRL_B, 8'h01);
        freq <= 6'h08;
        repeat (8) @(posedge clk);
        s0 = n_st;
        wr(ATD_ADDR_CTRL_B, 8'h04);
        repeat (8) @(posedge clk);
        `CHK(n_st - s0, 1)
        s0 = n_st;
        wr(ATD_ADDR_CTRL_B, 8'h00);
        repeat (8) @(posedge clk);
        `CHK(n_st - s0, 0)
        freq <= 6'h00;
        // software start, then the done flag rising restarts once only
        s0 = n_st;
        wr(ATD_ADDR_CTRL_A, 8'hF0);
        repeat (40) @(posedge clk);
        `CHK(n_st - s0, 2)
        $display("test source switching done");
        // second reset in mid-run: every register falls back to zero
        rst <= 1'b1;
        mdl_b = 8'h00;
        mdl_d = 8'h00;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(ATD_ADDR_CTRL_A, rv);
        `CHK(rv, 8'h00)
        rd(ATD_ADDR_CTRL_B, rv);
        `CHK(rv, mdl_b)
        `CHK(ibd, mdl_d[5:0])
        $display("test reset done");
        finish_test();
    end
endmodule
`default_nettype wire
